// *** include/csf_pkg.sv ***
// constants and field layout shared by the status and fault reporting block
`default_nettype none
package csf_pkg;
  // clock and time base
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned US_CYC        = US_NS / CLK_NS;
  localparam int unsigned PULSE_US      = 256;
  localparam int unsigned BLINK_HALF_US = 500000;
  localparam int unsigned US_CNT_W      = 5;
  localparam int unsigned PULSE_W       = 9;
  localparam int unsigned BLINK_W       = 19;
  // register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] A_CTRL  = 4'h1;
  localparam logic [3:0] A_LIVE  = 4'h8;
  localparam logic [3:0] A_FAULT = 4'h9;
  localparam logic [3:0] A_STAT  = 4'ha;
  localparam logic [7:0] RD_UNMAPPED = 8'hff;
  // control register fields
  localparam int unsigned CB_VREG_MASK = 0;
  localparam int unsigned CB_IREG_MASK = 1;
  localparam int unsigned CB_OVSEL     = 2;
  localparam int unsigned CB_BOOST     = 4;
  localparam logic [4:0]  CTRL_RST     = 5'h0c;
  // fault latch register fields
  localparam int unsigned F_CODE = 4;
  // charge fault codes
  localparam logic [1:0] CODE_OK    = 2'h0;
  localparam logic [1:0] CODE_INOV  = 2'h1;
  localparam logic [1:0] CODE_TSHUT = 2'h2;
  localparam logic [1:0] CODE_TIMER = 2'h3;
endpackage : csf_pkg
`default_nettype wire

// *** include/csf_time_if.sv ***
// time base strobes passed from the divider to its users
`timescale 1ns/1ps
`default_nettype none
interface csf_time_if;
  logic us_tick;
  logic blink;
  modport gen  (output us_tick, output blink);
  modport sink (input us_tick, input blink);
endinterface : csf_time_if
`default_nettype wire

// *** hw/csf_timebase.sv ***
// microsecond tick and indicator blink square wave
`timescale 1ns/1ps
`default_nettype none
module csf_timebase #(
  parameter int unsigned BLINK_HALF_US = csf_pkg::BLINK_HALF_US
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // strobes out
  csf_time_if.gen   tm
);
  import csf_pkg::*;

  typedef struct packed {
    logic [US_CNT_W-1:0] div;
    logic [BLINK_W-1:0]  bcnt;
    logic                tick;
    logic                blink;
  } csf_tb_s;

  csf_tb_s st;
  csf_tb_s next_st;

  // divide to 1 us, then count half periods of the blink
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.div == US_CNT_W'(US_CYC - 1))
    begin
      next_st.div = '0;
      next_st.tick = 1'b1;
    end
    else
      next_st.div = st.div + 1'b1;
    if (st.tick)
    begin
      if (st.bcnt == BLINK_W'(BLINK_HALF_US - 1))
      begin
        next_st.bcnt = '0;
        next_st.blink = ~st.blink; // equal high and low
      end
      else
        next_st.bcnt = st.bcnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tm.us_tick = st.tick;
  assign tm.blink   = st.blink;

  property p_tick_gap;
    @(posedge sys_clk) disable iff (!arst_n)
    st.tick |=> !st.tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("us tick not spaced");
endmodule : csf_timebase
`default_nettype wire

// *** hw/csf_pulser.sv ***
// stretches an event strobe into one active-low pulse of fixed width
`timescale 1ns/1ps
`default_nettype none
module csf_pulser #(
  parameter int unsigned PULSE_US = csf_pkg::PULSE_US
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // time base
  csf_time_if.sink  tm,
  // event in, line out
  input  wire logic fire,
  output logic      event_n
);
  import csf_pkg::*;

  typedef enum logic [1:0] {PS_IDLE = 2'b01, PS_LOW = 2'b10} csf_ps_e;

  typedef struct packed {
    csf_ps_e            state;
    logic [PULSE_W-1:0] cnt;
    logic               line_n;
  } csf_pl_s;

  csf_pl_s st;
  csf_pl_s next_st;

  // events arriving during a pulse merge into it, so no queueing needed
  always_comb
  begin
    next_st = st;
    unique case (st.state)
      PS_IDLE:
      begin
        if (fire)
        begin
          next_st.state = PS_LOW;
          next_st.cnt = '0;
          next_st.line_n = 1'b0; // one pulse per event seen while idle
        end
      end
      PS_LOW:
      begin
        if (tm.us_tick)
        begin
          if (st.cnt == PULSE_W'(PULSE_US - 1))
          begin
            next_st.state = PS_IDLE;
            next_st.line_n = 1'b1; // width counted in us ticks
          end
          else
            next_st.cnt = st.cnt + 1'b1;
        end
      end
      default:
        next_st.state = PS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{state: PS_IDLE, cnt: '0, line_n: 1'b1};
    else
      st <= next_st;
  end

  assign event_n = st.line_n;

  property p_pulse_len;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(event_n) |-> $past(st.cnt) == PULSE_W'(PULSE_US - 1);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("event pulse width wrong");

  property p_fire_low;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.state == PS_IDLE && fire) |=> !event_n [*2];
  endproperty
  a_fire_low: assert property (p_fire_low)
    else $error("event did not pull line low");
endmodule : csf_pulser
`default_nettype wire

// *** hw/csf_top.sv ***
// charger status, fault latching, indicator and event line logic
// Notes on behaviour
// - power good needs all five input conditions
// - indicator low charging, high idle, blinks suspended
// - each event while idle gives one 256 us low pulse
// - listed charger events raise an event pulse
// - regulation entry events, individually maskable, bits 1:0
// - fault and status changes held until read
// - no fault events while latched bits pending
// - first read returns held, second live
// - adapter path ok raises accessory power ok
// - switch overcurrent or 5.8 V drops accessory ok
// - accessory ok drops before boost starts
// - boost accessory ok within window, drops on exit
// - selectable input overvoltage stops switching, self-recovers
// - input overvoltage sets code 01, pulses
// - system overvoltage stops switching, enables discharge sink
// - boost overvoltage exits boost, sets fault, pulses
// - boost overcurrent latches off, sets fault, pulses
// - above 110 C reduce current, halve timer
// - above 150 C shut down, code 10, recover 130 C
// - boost shutdown clears enable, reset only below 145 C
// - battery overvoltage stops switching, sets bit, pulses
// - battery switch latch-offs with their exit events
// - safety timer expiry sets code 11, pulses
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module csf_top #(
  parameter int unsigned PULSE_US      = csf_pkg::PULSE_US,
  parameter int unsigned BLINK_HALF_US = csf_pkg::BLINK_HALF_US
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  // register port
  input  wire logic [csf_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [csf_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_we,
  input  wire logic                        reg_re,
  output logic      [csf_pkg::DATA_W-1:0]  reg_rdata,
  // input source comparators
  input  wire logic                        vbus_above_uvlo,
  input  wire logic                        vbus_above_bat,
  input  wire logic                        vbus_poor_ok,
  input  wire logic                        src_detect_done,
  input  wire logic                        src_identified,
  input  wire logic                        adapter_present,
  input  wire logic [3:0]                  in_ov_cmp,
  input  wire logic                        vbus_above_5v8,
  input  wire logic                        blk_overcurrent,
  // accessory node and boost
  input  wire logic                        acc_above_3v8,
  input  wire logic                        acc_above_5v8,
  input  wire logic                        boost_ocp,
  // system, battery and die temperature
  input  wire logic                        system_overvoltage,
  input  wire logic                        battery_overvoltage,
  input  wire logic                        bat_depleted,
  input  wire logic                        bat_overcurrent,
  input  wire logic                        ship_exit,
  input  wire logic                        tj_above_110,
  input  wire logic                        tj_above_130,
  input  wire logic                        tj_above_145,
  input  wire logic                        tj_above_150,
  // charger state
  input  wire logic                        charging,
  input  wire logic                        charge_done,
  input  wire logic                        ts_fault,
  input  wire logic [2:0]                  ntc_code,
  input  wire logic                        timer_expired,
  input  wire logic                        watchdog_fault,
  input  wire logic                        topoff_start,
  input  wire logic                        topoff_expire,
  input  wire logic                        input_voltage_regulation,
  input  wire logic                        input_current_regulation,
  // charge indicator pin, open drain
  input  wire logic                        stat_pin_i,
  output logic                             stat_pin_o,
  output logic                             stat_pin_oe_n,
  // status outputs
  output logic                             input_power_good_flag,
  output logic                             accessory_power_ok,
  output logic                             event_n,
  output logic [1:0]                       charge_fault_code,
  output logic                             battery_overvoltage_bit,
  output logic                             thermal_regulation_flag,
  output logic                             boost_enable_bit,
  output logic                             boost_run,
  // protection actions
  output logic                             switching_stop,
  output logic                             sys_discharge_en,
  output logic                             battery_switch_on,
  output logic                             charge_current_reduce,
  output logic                             term_disable,
  output logic                             timer_half_rate
);
  import csf_pkg::*;

  typedef struct packed {
    logic [4:0] ctrl;
    logic [7:0] fault_hold;
    logic [2:0] stat_hold;
    logic       stat_pend;
    logic [7:0] fault_prev;
    logic [2:0] stat_prev;
    logic [7:0] rdata;
    logic       pg;
    logic       acc_ok;
    logic       boost;
    logic       tshut;
    logic       odis_off;
    logic       ship_off;
    logic       adp_prev;
    logic       src_prev;
    logic       done_prev;
    logic [1:0] reg_prev;
    logic [1:0] code;
    logic       batov;
    logic       stat_low;
  } csf_top_s;

  csf_top_s   st;
  csf_top_s   next_st;
  logic [1:0] ov_sel;
  logic       in_ov;
  logic       pg_live;
  logic       buck;
  logic       therm;
  logic       bexit;
  logic       bfault;
  logic       suspend;
  logic       pend;
  logic       ev;
  logic [7:0] fault_live;
  logic [2:0] stat_live;
  logic [1:0] reg_rise;

  csf_time_if tm ();

  csf_timebase #(
    .BLINK_HALF_US (BLINK_HALF_US)
  ) u_timebase (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tm      (tm)
  );

  csf_pulser #(
    .PULSE_US (PULSE_US)
  ) u_pulser (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tm      (tm),
    .fire    (ev),
    .event_n (event_n)
  );

  // condition decode from the comparators
  always_comb
  begin
    ov_sel  = st.ctrl[CB_OVSEL +: 2];
    in_ov   = in_ov_cmp[ov_sel]; // selected threshold
    pg_live = vbus_above_uvlo & vbus_above_bat & ~in_ov
              & vbus_poor_ok & src_detect_done;
    buck    = ~st.boost;
    therm   = tj_above_110 & buck;
    bexit   = ~st.ctrl[CB_BOOST] | in_ov | ts_fault | bat_depleted
              | boost_ocp | acc_above_5v8 | tj_above_150
              | adapter_present;
    bfault  = st.boost & (acc_above_5v8 | boost_ocp);
    suspend = in_ov | ts_fault | timer_expired | system_overvoltage;
    fault_live = {watchdog_fault, bfault, st.code, st.batov, ntc_code};
    stat_live  = {st.pg, therm, st.acc_ok};
    pend       = (|st.fault_hold) | st.stat_pend;
    reg_rise   = {input_voltage_regulation, input_current_regulation}
                 & ~st.reg_prev
                 & ~{st.ctrl[CB_VREG_MASK], st.ctrl[CB_IREG_MASK]};
  end

  // event sources merged onto the single pulse request
  always_comb
  begin
    ev = (pg_live & ~st.pg)
       | (~adapter_present & st.adp_prev)
       | (src_identified & ~st.src_prev)
       | (charge_done & ~st.done_prev)
       | topoff_start | topoff_expire
       | (|reg_rise)
       | (((|(fault_live & ~st.fault_prev))
          | (stat_live != st.stat_prev)) & ~pend);
  end

  // next state of every register of the block
  always_comb
  begin
    next_st = st;
    next_st.pg = pg_live;
    next_st.adp_prev  = adapter_present;
    next_st.src_prev  = src_identified;
    next_st.done_prev = charge_done;
    next_st.reg_prev  = {input_voltage_regulation, input_current_regulation};
    next_st.batov     = battery_overvoltage;
    // thermal shutdown with hysteresis down to 130 C
    if (tj_above_150)
      next_st.tshut = 1'b1;
    else if (!tj_above_130)
      next_st.tshut = 1'b0;
    // one code at a time; input overvoltage outranks the rest
    if (in_ov)
      next_st.code = CODE_INOV;
    else if (st.tshut && buck)
      next_st.code = CODE_TSHUT;
    else if (timer_expired)
      next_st.code = CODE_TIMER;
    else
      next_st.code = CODE_OK;
    // host write; setting boost refused while the die is hot
    if (reg_we && reg_addr == A_CTRL)
    begin
      next_st.ctrl = reg_wdata[4:0];
      if (reg_wdata[CB_BOOST] && !st.ctrl[CB_BOOST] && tj_above_145)
        next_st.ctrl[CB_BOOST] = 1'b0;
    end
    // hardware clear beats a host write in the same cycle
    if (bfault || (st.boost && tj_above_150))
      next_st.ctrl[CB_BOOST] = 1'b0;
    // boost may only start after the accessory output has dropped
    if (st.boost)
      next_st.boost = ~bexit;
    else
      next_st.boost = ~bexit & ~st.acc_ok;
    if (adapter_present)
      next_st.acc_ok = vbus_above_bat & ~in_ov & vbus_poor_ok
                       & ~blk_overcurrent & ~vbus_above_5v8;
    else
      next_st.acc_ok = st.boost & ~bexit & acc_above_3v8
                       & ~acc_above_5v8;
    // battery switch latch-offs
    if (bat_depleted)
      next_st.odis_off = 1'b1;
    else if (adapter_present && !st.adp_prev)
      next_st.odis_off = 1'b0;
    if (bat_overcurrent)
      next_st.ship_off = 1'b1;
    else if (ship_exit)
      next_st.ship_off = 1'b0;
    // latched fault and status; set always wins over the read clear
    next_st.fault_prev = fault_live;
    next_st.stat_prev  = stat_live;
    next_st.fault_hold = st.fault_hold | fault_live;
    if (st.fault_hold[F_CODE +: 2] != CODE_OK)
      next_st.fault_hold[F_CODE +: 2] = st.fault_hold[F_CODE +: 2];
    if (!st.stat_pend)
    begin
      next_st.stat_hold = stat_live;
      next_st.stat_pend = stat_live != st.stat_prev;
    end
    if (reg_re && reg_addr == A_FAULT)
      next_st.fault_hold = fault_live;
    if (reg_re && reg_addr == A_STAT)
    begin
      next_st.stat_hold = stat_live;
      next_st.stat_pend = stat_live != st.stat_prev; // change still latches
    end
    // read data, one cycle after the strobe
    if (reg_re)
    begin
      unique case (reg_addr)
        A_CTRL:  next_st.rdata = {3'h0, st.ctrl};
        A_LIVE:  next_st.rdata = {stat_pin_i, st.pg, st.acc_ok, st.boost,
                                  st.tshut, therm, input_voltage_regulation,
                                  input_current_regulation};
        A_FAULT: next_st.rdata = st.fault_hold;
        A_STAT:  next_st.rdata = {1'h0, st.stat_hold, 2'h0,
                                  input_voltage_regulation,
                                  input_current_regulation};
        default: next_st.rdata = RD_UNMAPPED;
      endcase
    end
    // indicator: blink on suspend, low while charging, else released
    if (suspend)
      next_st.stat_low = tm.blink;
    else
      next_st.stat_low = charging;
  end

  // power-on state: latches empty, indicator released
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.ctrl <= CTRL_RST; // default threshold is the highest
    end
    else
      st <= next_st;
  end

  // outputs
  assign reg_rdata               = st.rdata;
  assign stat_pin_o              = 1'b0;
  assign stat_pin_oe_n           = ~st.stat_low;
  assign input_power_good_flag   = st.pg;
  assign accessory_power_ok      = st.acc_ok;
  assign charge_fault_code       = st.code;
  assign battery_overvoltage_bit = st.batov;
  assign thermal_regulation_flag = therm;
  assign boost_enable_bit        = st.ctrl[CB_BOOST];
  assign boost_run               = st.boost;
  assign charge_current_reduce   = therm;
  assign term_disable            = therm;
  assign timer_half_rate         = therm;
  // switching stop acts at once on its inputs; shutdown and the battery switch latch-offs act through registers
  assign switching_stop    = in_ov | system_overvoltage | battery_overvoltage
                             | bfault | (st.tshut & buck);
  assign sys_discharge_en  = system_overvoltage;
  assign battery_switch_on = ~(st.odis_off | st.ship_off
                               | (st.tshut & buck));

  property p_pg_cause;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(input_power_good_flag) |-> $past(src_detect_done && vbus_poor_ok);
  endproperty
  a_pg_cause: assert property (p_pg_cause)
    else $error("power good without its conditions");

  property p_inov_code;
    @(posedge sys_clk) disable iff (!arst_n)
    in_ov |-> switching_stop ##1 charge_fault_code == CODE_INOV;
  endproperty
  a_inov_code: assert property (p_inov_code)
    else $error("input overvoltage code missing");

  property p_sink;
    @(posedge sys_clk) disable iff (!arst_n)
    system_overvoltage |-> sys_discharge_en && switching_stop;
  endproperty
  a_sink: assert property (p_sink)
    else $error("system overvoltage not handled");

  property p_boost_after_drop;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(boost_run) |-> !$past(accessory_power_ok);
  endproperty
  a_boost_after_drop: assert property (p_boost_after_drop)
    else $error("boost began with accessory output on");

  property p_first_read;
    @(posedge sys_clk) disable iff (!arst_n)
    (reg_re && reg_addr == A_FAULT) |=> reg_rdata == $past(st.fault_hold);
  endproperty
  a_first_read: assert property (p_first_read)
    else $error("fault read did not return held value");

  property p_charge_low;
    @(posedge sys_clk) disable iff (!arst_n)
    (charging && !suspend) |=> !stat_pin_oe_n;
  endproperty
  a_charge_low: assert property (p_charge_low)
    else $error("indicator not driven while charging");

  property p_tshut_off;
    @(posedge sys_clk) disable iff (!arst_n)
    (tj_above_150 && !boost_run) |=> ##1 !battery_switch_on;
  endproperty
  a_tshut_off: assert property (p_tshut_off)
    else $error("battery switch on in shutdown");
endmodule : csf_top
`default_nettype wire

// *** verif/csf_host.sv ***
// host model: register accesses on the plain port
`timescale 1ns/1ps
`default_nettype none
module csf_host (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic [3:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_we,
  output logic            reg_re,
  input  wire logic [7:0] reg_rdata
);
  // idle bus from time zero
  initial
  begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
  end
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_we    <= 1'b1;
    @(posedge sys_clk);
    reg_we    <= 1'b0;
  endtask : wr
  // data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge sys_clk);
    reg_re   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  // latched bytes need a second read for live state
  task automatic rd2(input logic [3:0] a, output logic [7:0] h, l);
    rd(a, h);
    rd(a, l);
  endtask : rd2
endmodule : csf_host
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the status and fault block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csf_pkg::*;
  logic       sys_clk, arst_n, reg_we, reg_re;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, h, l;
  logic [1:0] charge_fault_code;
  bit   [3:0] in_ov_cmp;
  bit   [2:0] ntc_code;
  bit vbus_above_uvlo, vbus_above_bat, vbus_poor_ok, src_detect_done,
    src_identified, adapter_present, vbus_above_5v8, blk_overcurrent,
    acc_above_3v8, acc_above_5v8, boost_ocp, system_overvoltage,
    battery_overvoltage, bat_depleted, bat_overcurrent, ship_exit,
    tj_above_110, tj_above_130, tj_above_145, tj_above_150, charging,
    charge_done, ts_fault, timer_expired, watchdog_fault, topoff_start,
    topoff_expire, input_voltage_regulation, input_current_regulation;
  logic stat_pin_o, stat_pin_oe_n, input_power_good_flag, event_n,
    accessory_power_ok, battery_overvoltage_bit, thermal_regulation_flag,
    boost_enable_bit, boost_run, switching_stop, sys_discharge_en,
    battery_switch_on, charge_current_reduce, term_disable, timer_half_rate;
  wire logic  stat_pin_i;
  int         error_cnt = 0, total_checks = 0, cyc = 0;
  // pull-up on the open-drain indicator
  assign stat_pin_i = stat_pin_oe_n ? 1'b1 : stat_pin_o;
  // 50 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // short counts keep the run brief
  csf_top #(.PULSE_US(4), .BLINK_HALF_US(4)) dut (.*);
  csf_host host (.*);
  // hang guard, far above the planned run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, e, input string m);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %0t: %s", $time, m);
    end
  endtask : chk
  // settle past the edge so updates have landed
  task automatic st(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : st
  // one low pulse of 61..80 cycles with 4 us ticks
  task automatic ev();
    int n;
    int w;
    n = 0;
    w = 0;
    #1;
    while (event_n !== 1'b0 && n < 8)
    begin
      st(1);
      n++;
    end
    while (event_n === 1'b0 && w < 200)
    begin
      st(1);
      w++;
    end
    chk(8'(w >= 61 && w <= 80), 8'h01, "pulse width");
  endtask : ev
  task automatic nev(input string m);
    int n;
    n = 0;
    repeat (40)
    begin
      st(1);
      if (event_n !== 1'b1)
        n++;
    end
    chk(8'(n), 8'h00, m);
  endtask : nev
  // drain both latches, let stray pulses end
  task automatic clr();
    st(100);
    host.rd2(A_FAULT, h, l);
    host.rd2(A_STAT, h, l);
    st(100);
  endtask : clr
  task automatic t_pg();
    @(posedge sys_clk);
    vbus_above_uvlo <= 1'b1;
    vbus_above_bat  <= 1'b1;
    vbus_poor_ok    <= 1'b1;
    adapter_present <= 1'b1;
    ev();
    chk(8'(accessory_power_ok), 8'h01, "acc ok");
    chk(8'(input_power_good_flag), 8'h00, "pg early");
    @(posedge sys_clk);
    src_detect_done <= 1'b1;
    st(3);
    chk(8'(input_power_good_flag), 8'h01, "pg");
    clr();
    host.rd2(A_STAT, h, l);
    chk(l, 8'h50, "live status");
    @(posedge sys_clk);
    vbus_above_5v8 <= 1'b1;
    st(3);
    chk(8'(accessory_power_ok), 8'h00, "acc high v");
    @(posedge sys_clk);
    vbus_above_5v8 <= 1'b0;
  endtask : t_pg
  // a second fault is held back while the first waits
  task automatic t_ov();
    @(posedge sys_clk);
    in_ov_cmp <= 4'h8;
    ev();
    chk(8'(charge_fault_code), 8'(CODE_INOV), "ov code");
    chk(8'(switching_stop), 8'h01, "ov stop");
    @(posedge sys_clk);
    battery_overvoltage <= 1'b1;
    nev("event while pending");
    chk(8'(battery_overvoltage_bit), 8'h01, "bat ov");
    @(posedge sys_clk);
    in_ov_cmp           <= 4'h0;
    battery_overvoltage <= 1'b0;
    st(3);
    chk(8'(switching_stop), 8'h00, "ov resume");
    host.rd2(A_FAULT, h, l);
    chk(h & 8'h38, 8'h18, "held faults");
    chk(l & 8'h38, 8'h00, "live faults");
  endtask : t_ov
  task automatic t_th();
    @(posedge sys_clk);
    tj_above_110 <= 1'b1;
    st(2);
    d = {4'h0, thermal_regulation_flag, charge_current_reduce,
      term_disable, timer_half_rate};
    chk(d, 8'h0f, "thermal reg");
    @(posedge sys_clk);
    tj_above_130 <= 1'b1;
    tj_above_145 <= 1'b1;
    tj_above_150 <= 1'b1;
    st(2);
    chk(8'(charge_fault_code), 8'(CODE_TSHUT), "tshut code");
    chk(8'(battery_switch_on), 8'h00, "tshut off");
    host.wr(A_CTRL, 8'h1c);
    st(2);
    chk(8'(boost_enable_bit), 8'h00, "boost hot");
    @(posedge sys_clk);
    tj_above_150 <= 1'b0;
    tj_above_145 <= 1'b0;
    st(2);
    chk(8'(battery_switch_on), 8'h00, "hysteresis");
    @(posedge sys_clk);
    tj_above_130 <= 1'b0;
    tj_above_110 <= 1'b0;
    system_overvoltage <= 1'b1;
    st(2);
    chk(8'(battery_switch_on), 8'h01, "tshut recover");
    chk(8'({sys_discharge_en, switching_stop}), 8'h03, "sys ov");
    @(posedge sys_clk);
    system_overvoltage <= 1'b0;
  endtask : t_th
  task automatic t_st();
    @(posedge sys_clk);
    charging <= 1'b1;
    st(2);
    chk(8'({stat_pin_oe_n, stat_pin_i}), 8'h00, "stat chg");
    @(posedge sys_clk);
    charging <= 1'b0;
    st(2);
    chk(8'({stat_pin_oe_n, stat_pin_i}), 8'h03, "stat idle");
  endtask : t_st
  task automatic t_rg();
    host.wr(A_CTRL, 8'h0d);
    @(posedge sys_clk);
    input_voltage_regulation <= 1'b1;
    nev("masked");
    clr();
    @(posedge sys_clk);
    input_current_regulation <= 1'b1;
    ev();
    clr();
    @(posedge sys_clk);
    topoff_start <= 1'b1;
    @(posedge sys_clk);
    topoff_start <= 1'b0;
    ev();
  endtask : t_rg
  // boost on battery, then an over-current exit
  task automatic t_bs();
    @(posedge sys_clk);
    adapter_present <= 1'b0;
    acc_above_3v8   <= 1'b1;
    st(3);
    chk(8'(accessory_power_ok), 8'h00, "acc off unplugged");
    host.wr(A_CTRL, 8'h1d);
    st(3);
    chk(8'({boost_run, accessory_power_ok}), 8'h03, "boost acc");
    clr();
    @(posedge sys_clk);
    boost_ocp <= 1'b1;
    ev();
    d = {5'h0, boost_enable_bit, boost_run, accessory_power_ok};
    chk(d, 8'h00, "boost fault exit");
    host.rd2(A_FAULT, h, l);
    chk(h & 8'h40, 8'h40, "boost fault bit");
    @(posedge sys_clk);
    boost_ocp <= 1'b0;
  endtask : t_bs
  // each select listens to its own comparator only
  task automatic t_sel();
    for (int i = 0; i < 4; i++)
    begin
      host.wr(A_CTRL, 8'(i << 2));
      @(posedge sys_clk);
      in_ov_cmp <= ~(4'h1 << i);
      st(3);
      chk(8'(switching_stop), 8'h00, "other sel");
      @(posedge sys_clk);
      in_ov_cmp <= 4'h1 << i;
      st(3);
      chk(8'(switching_stop), 8'h01, "sel trip");
    end
  endtask : t_sel
  initial
  begin
    arst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    st(1);
    d = {4'h0, event_n, stat_pin_oe_n, input_power_good_flag,
      accessory_power_ok};
    chk(d, 8'h0c, "idle lines");
    host.rd(A_CTRL, d);
    chk(d, 8'h0c, "ctrl reset");
    host.rd(4'h3, d);
    chk(d, RD_UNMAPPED, "unmapped");
    t_pg();
    clr();
    t_ov();
    clr();
    t_th();
    clr();
    t_st();
    t_rg();
    clr();
    t_bs();
    t_sel();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
